// ### design/mpg_map.svh
`ifndef MPG_MAP_SVH
`define MPG_MAP_SVH
// Behaviour
// - Tick clock is bus clock divided by 1, 2, 4 or 8 per divider code.
// - A new divider selection takes effect when the next period begins, or at once while the period is zero.
// - Halt-in-wait clear: block runs on unchanged through wait mode.
// - Halt-in-wait set: wait mode freezes the prescaler and period counter and releases the pins; the bus still answers.
// - Resolution bit clear: 11-bit PWM, duty registers read and written as words.
// - Resolution bit set: 7-bit PWM, duty registers read and written as bytes.
// - Dither enable bit switches the dither feature on or off.
// - Overflow flag sets on every period overflow, stays until cleared or reset.
// - Writing one clears the overflow flag; writing zero leaves it.
// - Interrupt raised while overflow flag and its enable are both set.
// - Recirculation bit acts only in full bridge modes; half bridge is active low.
// - Recirculation bit set inverts the sign bit effect in full bridge modes.
// - High-side recirculation: PWM active low, static output high.
// - Low-side recirculation: PWM active high, static output low.
// - A period lasts the programmed period value in ticks (bit 0 dropped while dither is on), then overflows.
// - Byte-layout duty writes force D10, D9, D1, D0 to zero; layout only.

// Register indices; byte address is four times the index
`define MPG_IDX_CFG_MAIN  6'h00
`define MPG_IDX_CFG_AUX   6'h01
`define MPG_IDX_PERIOD    6'h02
`define MPG_IDX_DUTY_BASE 6'h20

// Main configuration fields
`define MPG_MAIN_FLAG_BIT 0
`define MPG_MAIN_DITHER_ENABLE_BIT 2
`define MPG_MAIN_FAST_BIT 3
`define MPG_MAIN_HALT_BIT 4
`define MPG_MAIN_DIV_LSB  5
`define MPG_MAIN_DIV_MSB  6

// Auxiliary configuration fields
`define MPG_AUX_IRQEN_BIT 0
`define MPG_AUX_RECIRCULATION_SIDE_SELECT_BIT 7

// Duty layout fields
`define MPG_DUTY_SIGN_BIT 15

// Reset values
`define MPG_RST_BYTE  8'h00
`define MPG_RST_WORD  16'h0000
`endif

// ### design/mpg_pkg.sv
package mpg_pkg;
	// Tick divider codes
	typedef enum logic [1:0] {
		MPG_DIV_1 = 2'b00,
		MPG_DIV_2 = 2'b01,
		MPG_DIV_4 = 2'b10,
		MPG_DIV_8 = 2'b11
	} mpg_div_t;

	// Stored duty word: sign and eleven duty bits
	typedef struct packed {
		logic        sign;
		logic [10:0] duty;
	} mpg_duty_t;
endpackage

// ### design/mpg_top.sv
`include "mpg_map.svh"

module mpg_top #(
	parameter int CHANNELS = 8,
	parameter int PER_W    = 11
) (
	// Clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	// Wishbone classic slave
	input  wire logic                    cyc_i,
	input  wire logic                    stb_i,
	input  wire logic                    we_i,
	input  wire logic [7:0]              adr_i,
	input  wire logic [3:0]              sel_i,
	input  wire logic [31:0]             dat_i,
	output logic      [31:0]             dat_o,
	output logic                         ack_o,
	// System state
	input  wire logic                    wait_mode_i,
	// Interrupt
	output logic                         irq_o,
	// Towards the waveform engine
	output logic                         tick_o,
	output logic                         overflow_o,
	output logic                         fast_mode_o,
	output logic                         dither_o,
	output logic                         pins_release_o,
	output logic                         full_active_high_o,
	output logic                         full_static_level_o,
	output logic                         full_sign_invert_o,
	output logic                         half_active_high_o,
	output logic [CHANNELS*12-1:0]       duty_o,
	output logic [PER_W-1:0]             period_o
);

	// ------------------------------------------------------------
	// Parameter checks
	// ------------------------------------------------------------
	// Duty layout and register map are fixed at eleven bits, eight slots
	// Refused at elaboration, before any clock runs
	if (PER_W != 11 || CHANNELS < 1 || CHANNELS > 8) begin : g_bad_param
		$error("mpg_top: unsupported PER_W or CHANNELS");
	end

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	mpg_pkg::mpg_div_t     div_sel_q;
	mpg_pkg::mpg_div_t     div_act_q;
	logic                  halt_sel_q;
	logic                  fast_q;
	logic                  dither_enable_q;
	logic                  flag_q;
	logic                  irq_en_q;
	logic                  recirculation_side_select_q;
	logic [PER_W-1:0]      period_q;
	mpg_pkg::mpg_duty_t    duty_q [CHANNELS];

	// Counter state
	logic [2:0]            pre_cnt_q;
	logic [PER_W-1:0]      per_cnt_q;
	logic                  tick_q;
	logic                  ovf_q;
	logic                  ack_q;
	logic [31:0]           rdata_q;
	logic                  irq_q;
	logic                  release_q;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic                  req;
	logic                  wr;
	logic [5:0]            idx;
	logic                  hit_main;
	logic                  hit_aux;
	logic                  hit_per;
	logic                  hit_duty;
	logic [2:0]            duty_sel;

	// One-cycle answer; ack drops the cycle after it was given
	assign req      = cyc_i & stb_i & ~ack_q;
	assign wr       = req & we_i;
	assign idx      = adr_i[7:2];
	assign hit_main = (idx == `MPG_IDX_CFG_MAIN);
	assign hit_aux  = (idx == `MPG_IDX_CFG_AUX);
	assign hit_per  = (idx == `MPG_IDX_PERIOD);
	assign duty_sel = idx[2:0];
	assign hit_duty = (idx[5:3] == `MPG_IDX_DUTY_BASE >> 3)
	                  && (32'(duty_sel) < CHANNELS);

	// ------------------------------------------------------------
	// Wait-mode halt
	// ------------------------------------------------------------
	logic                  halted;

	// Only a set halt bit lets wait mode freeze the counters
	assign halted = wait_mode_i & halt_sel_q;

	// Pin release follows the halt with one register stage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			release_q <= 1'b0;
		end else begin
			release_q <= halted;
		end
	end

	// ------------------------------------------------------------
	// Main configuration register
	// ------------------------------------------------------------
	logic                  wr_main;

	assign wr_main = wr & hit_main & sel_i[0];

	// Divider, halt, resolution and dither bits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_sel_q  <= mpg_pkg::MPG_DIV_1;
			halt_sel_q <= 1'b0;
			fast_q     <= 1'b0;
			dither_enable_q     <= 1'b0;
		end else if (wr_main) begin
			div_sel_q  <= mpg_pkg::mpg_div_t'(
				dat_i[`MPG_MAIN_DIV_MSB:`MPG_MAIN_DIV_LSB]);
			halt_sel_q <= dat_i[`MPG_MAIN_HALT_BIT];
			fast_q     <= dat_i[`MPG_MAIN_FAST_BIT];
			dither_enable_q     <= dat_i[`MPG_MAIN_DITHER_ENABLE_BIT];
		end
	end

	// Overflow flag; a same-cycle overflow beats the clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_q <= 1'b0;
		end else if (ovf_q) begin
			flag_q <= 1'b1;
		end else if (wr_main && dat_i[`MPG_MAIN_FLAG_BIT]) begin
			flag_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Auxiliary configuration register
	// ------------------------------------------------------------
	// Recirculation side and interrupt enable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			recirculation_side_select_q <= 1'b0;
			irq_en_q <= 1'b0;
		end else if (wr & hit_aux & sel_i[0]) begin
			// Changing this mid full-bridge can glitch the coils
			recirculation_side_select_q <= dat_i[`MPG_AUX_RECIRCULATION_SIDE_SELECT_BIT];
			irq_en_q <= dat_i[`MPG_AUX_IRQEN_BIT];
		end
	end

	// ------------------------------------------------------------
	// Period register
	// ------------------------------------------------------------
	// Low byte and high byte lanes written independently
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			period_q <= PER_W'(`MPG_RST_WORD);
		end else if (wr & hit_per) begin
			if (sel_i[0]) begin
				period_q[7:0] <= dat_i[7:0];
			end
			if (sel_i[1]) begin
				period_q[PER_W-1:8] <= dat_i[PER_W-1:8];
			end
		end
	end

	// ------------------------------------------------------------
	// Duty registers
	// ------------------------------------------------------------
	// Layout depends only on the resolution bit at access time
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < CHANNELS; i++) begin
				duty_q[i] <= '0;
			end
		end else if (wr & hit_duty) begin
			if (fast_q) begin
				// Byte layout: D[8:2] from the high byte
				if (sel_i[1]) begin
					duty_q[duty_sel].sign       <= dat_i[`MPG_DUTY_SIGN_BIT];
					duty_q[duty_sel].duty[8:2]  <= dat_i[14:8];
					duty_q[duty_sel].duty[10:9] <= 2'b00;
					duty_q[duty_sel].duty[1:0]  <= 2'b00;
				end
			end else begin
				// Word layout: sign on top, D[10:0] low
				if (sel_i[1]) begin
					duty_q[duty_sel].sign       <= dat_i[`MPG_DUTY_SIGN_BIT];
					duty_q[duty_sel].duty[10:8] <= dat_i[10:8];
				end
				if (sel_i[0]) begin
					duty_q[duty_sel].duty[7:0]  <= dat_i[7:0];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	logic [31:0]           rdata_d;
	mpg_pkg::mpg_duty_t    rd_duty;

	// Unmapped indices read as zero and ignore writes
	always_comb begin
		rdata_d = 32'h0000_0000;
		rd_duty = duty_q[duty_sel];
		if (hit_main) begin
			rdata_d[`MPG_MAIN_DIV_MSB:`MPG_MAIN_DIV_LSB] = div_sel_q;
			rdata_d[`MPG_MAIN_HALT_BIT] = halt_sel_q;
			rdata_d[`MPG_MAIN_FAST_BIT] = fast_q;
			rdata_d[`MPG_MAIN_DITHER_ENABLE_BIT] = dither_enable_q;
			rdata_d[`MPG_MAIN_FLAG_BIT] = flag_q;
		end else if (hit_aux) begin
			rdata_d[`MPG_AUX_RECIRCULATION_SIDE_SELECT_BIT] = recirculation_side_select_q;
			rdata_d[`MPG_AUX_IRQEN_BIT]  = irq_en_q;
		end else if (hit_per) begin
			rdata_d[PER_W-1:0] = period_q;
			// Dither ignores and hides the lowest period bit
			rdata_d[0] = period_q[0] & ~dither_enable_q;
		end else if (hit_duty) begin
			rdata_d[`MPG_DUTY_SIGN_BIT] = rd_duty.sign;
			if (fast_q) begin
				rdata_d[14:8] = rd_duty.duty[8:2];
			end else begin
				rdata_d[10:0] = rd_duty.duty;
			end
		end
	end

	// Answer one cycle after the request is seen
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q   <= req;
			rdata_q <= req ? rdata_d : 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------
	// Prescaler
	// ------------------------------------------------------------
	logic [2:0]            pre_lim;
	logic                  tick;

	// Terminal count from the active, not the written, divider
	always_comb begin
		unique case (div_act_q)
			mpg_pkg::MPG_DIV_1: pre_lim = 3'd0;
			mpg_pkg::MPG_DIV_2: pre_lim = 3'd1;
			mpg_pkg::MPG_DIV_4: pre_lim = 3'd3;
			mpg_pkg::MPG_DIV_8: pre_lim = 3'd7;
		endcase
	end

	assign tick = ~halted && (pre_cnt_q == pre_lim);

	// Free-running divide counter, frozen while halted
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_cnt_q <= 3'd0;
		end else if (halted) begin
			pre_cnt_q <= pre_cnt_q;
		end else if (tick) begin
			pre_cnt_q <= 3'd0;
		end else begin
			pre_cnt_q <= pre_cnt_q + 3'd1;
		end
	end

	// ------------------------------------------------------------
	// Period counter
	// ------------------------------------------------------------
	logic [PER_W-1:0]      eff_per;
	logic                  per_end;
	logic                  per_idle;

	// Dither doubles granularity: lowest bit dropped, so 1 acts as 0
	assign eff_per  = dither_enable_q ? {period_q[PER_W-1:1], 1'b0} : period_q;
	assign per_idle = (eff_per == '0);
	// A shrunk period or newly set dither must not let the count run past its end
	assign per_end  = tick && !per_idle && (per_cnt_q >= eff_per - PER_W'(1));

	// Count ticks from zero to the period length less one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			per_cnt_q <= '0;
		end else if (per_idle) begin
			per_cnt_q <= '0;
		end else if (per_end) begin
			per_cnt_q <= '0;
		end else if (tick) begin
			per_cnt_q <= per_cnt_q + PER_W'(1);
		end
	end

	// New divider only at a period boundary, or at once when idle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_act_q <= mpg_pkg::MPG_DIV_1;
		end else if (per_end || per_idle) begin
			div_act_q <= div_sel_q;
		end
	end

	// Registered tick and overflow pulses
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_q <= 1'b0;
			ovf_q  <= 1'b0;
		end else begin
			tick_q <= tick;
			ovf_q  <= per_end;
		end
	end

	// ------------------------------------------------------------
	// Interrupt
	// ------------------------------------------------------------
	// Level request while flag and enable are both set
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= flag_q & irq_en_q;
		end
	end

	// ------------------------------------------------------------
	// Output levels for the waveform engine
	// ------------------------------------------------------------
	logic                  lvl_active_q;
	logic                  lvl_static_q;
	logic                  lvl_sign_q;
	logic                  lvl_half_q;

	// Full bridge levels follow recirculation; half bridge is fixed
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lvl_active_q <= 1'b0;
			lvl_static_q <= 1'b1;
			lvl_sign_q   <= 1'b0;
			lvl_half_q   <= 1'b0;
		end else begin
			lvl_active_q <= recirculation_side_select_q;
			lvl_static_q <= ~recirculation_side_select_q;
			lvl_sign_q   <= recirculation_side_select_q;
			lvl_half_q   <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Port drive
	// ------------------------------------------------------------
	assign dat_o               = rdata_q;
	assign ack_o               = ack_q;
	assign irq_o               = irq_q;
	assign tick_o              = tick_q;
	assign overflow_o          = ovf_q;
	assign fast_mode_o         = fast_q;
	assign dither_o            = dither_enable_q;
	assign pins_release_o      = release_q;
	assign full_active_high_o  = lvl_active_q;
	assign full_static_level_o = lvl_static_q;
	assign full_sign_invert_o  = lvl_sign_q;
	assign half_active_high_o  = lvl_half_q;
	assign period_o            = period_q;

	// Flatten working duty words, channel 0 lowest
	for (genvar g = 0; g < CHANNELS; g++) begin : g_duty
		assign duty_o[g*12 +: 12] = duty_q[g];
	end

endmodule

// ### tb/mpg_props.sv
module mpg_props (
	// Clock, reset and bus
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	// Status and engine side
	input wire logic        wait_mode_i,
	input wire logic        irq_o,
	input wire logic        tick_o,
	input wire logic        overflow_o,
	input wire logic        fast_mode_o,
	input wire logic        dither_o,
	input wire logic        pins_release_o,
	input wire logic        full_active_high_o,
	input wire logic        full_static_level_o,
	input wire logic        full_sign_invert_o,
	input wire logic        half_active_high_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ----------------------------------------
	// Bus and status relations
	// ----------------------------------------
	sequence s_take;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_answer;
		ack_o ##1 !ack_o;
	endsequence

	chk_bus_answer: assert property (s_take |=> s_answer)
		else $error("no single ack after request");
	chk_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	chk_idle_data: assert property (!ack_o |-> dat_o == 32'h0000_0000)
		else $error("read data outside ack");
	chk_half_low: assert property (!half_active_high_o)
		else $error("half bridge not active low");
	chk_recirculation_side_select_pair: assert property (full_static_level_o == !full_active_high_o &&
		full_sign_invert_o == full_active_high_o)
		else $error("recirculation outputs disagree");
	// Overflow and its ending tick leave the same edge, so they stand together
	chk_ovf_after_tick: assert property (overflow_o |-> tick_o)
		else $error("overflow without ending tick");
	chk_pins_wait: assert property (pins_release_o |-> $past(wait_mode_i))
		else $error("pins released outside wait");
	// Sticky flag keeps the request up while software stays away
	chk_irq_hold: assert property (irq_o && !stb_i && !$past(stb_i) |=> irq_o)
		else $error("interrupt dropped on its own");
	chk_reset_state: assert property ($past(rst_i) |-> !irq_o && !fast_mode_o &&
		!dither_o && !pins_release_o && full_static_level_o)
		else $error("state after reset wrong");
endmodule

bind mpg_top mpg_props i_mpg_props (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
	.ack_o(ack_o), .wait_mode_i(wait_mode_i), .irq_o(irq_o), .tick_o(tick_o),
	.overflow_o(overflow_o), .fast_mode_o(fast_mode_o), .dither_o(dither_o),
	.pins_release_o(pins_release_o), .full_active_high_o(full_active_high_o),
	.full_static_level_o(full_static_level_o), .full_sign_invert_o(full_sign_invert_o),
	.half_active_high_o(half_active_high_o)
);

// ### tb/mpg_engine_model.sv
module mpg_engine_model (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Timing from the control block
	input  wire logic tick_i,
	input  wire logic overflow_i,
	// Observed figures
	output int        tick_cnt_o,
	output int        ovf_cnt_o,
	output int        gap_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int run;

	// Engine counts ticks and measures bus clocks per period
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt_o <= 0;
			ovf_cnt_o <= 0;
			gap_o <= 0;
			run <= 1;
		end else begin
			tick_cnt_o <= tick_cnt_o + int'(tick_i);
			run <= overflow_i ? 1 : run + 1;
			if (overflow_i) begin
				ovf_cnt_o <= ovf_cnt_o + 1;
				gap_o <= run;
			end
		end
	end
endmodule

// ### tb/motor_pwm_global_control_test.sv
module motor_pwm_global_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, wait_mode_i = 0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0000_0000, dat_o, rd;
	logic ack_o, irq_o, tick_o, overflow_o, fast_mode_o, dither_o, pins_release_o;
	logic full_active_high_o, full_static_level_o, full_sign_invert_o, half_active_high_o;
	logic [95:0] duty_o;
	logic [10:0] period_o;
	int error_cnt = 0, compares = 0, tick_cnt, ovf_cnt, gap, t0;

	mpg_top i_mpg_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .wait_mode_i(wait_mode_i), .irq_o(irq_o), .tick_o(tick_o),
		.overflow_o(overflow_o), .fast_mode_o(fast_mode_o), .dither_o(dither_o),
		.pins_release_o(pins_release_o), .full_active_high_o(full_active_high_o),
		.full_static_level_o(full_static_level_o), .full_sign_invert_o(full_sign_invert_o),
		.half_active_high_o(half_active_high_o), .duty_o(duty_o), .period_o(period_o));
	mpg_engine_model i_mpg_engine_model (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick_o),
		.overflow_i(overflow_o), .tick_cnt_o(tick_cnt), .ovf_cnt_o(ovf_cnt), .gap_o(gap));

	always #5 clk_i = ~clk_i;

	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task results();
		if (error_cnt == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Single classic cycle; ack and read data taken at one rising edge, then released
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, s};
		for (n = 0; n < 20; n++) begin
			@(posedge clk_i);
			if (ack_o === 1'b1) break;
		end
		if (n == 20) begin
			error_cnt++;
			results();
		end
		rd = dat_o;
		{cyc_i, stb_i} <= 2'b00;
	endtask
	task wait_ovf();
		int c, n;
		c = ovf_cnt;
		for (n = 0; n < 300 && ovf_cnt == c; n++) @(posedge clk_i);
		if (n == 300) begin
			error_cnt++;
			results();
		end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, 8'h00, 0, 4'hF);
		chk(rd, 32'h0000_0000);
		wb(0, 8'h04, 0, 4'hF);
		chk(rd, 32'h0000_0000);
		wb(1, 8'hFC, 32'hFFFF_FFFF, 4'hF);
		wb(0, 8'hFC, 0, 4'hF);
		chk(rd, 32'h0000_0000);
		// Recirculation swapped only while no bridge mode runs
		wb(1, 8'h04, 32'h0000_0080, 4'h1);
		wb(0, 8'h04, 0, 4'hF);
		chk(rd, 32'h0000_0080);
		chk({full_active_high_o, full_static_level_o, full_sign_invert_o,
			half_active_high_o}, 4'b1010);
		wb(1, 8'h04, 32'h0000_0000, 4'h1);
		repeat (2) @(posedge clk_i);
		chk({full_active_high_o, full_static_level_o}, 2'b01);
		// Byte layout keeps only D8..D2 from the upper lane
		wb(1, 8'h00, 32'h0000_000C, 4'h1);
		wb(1, 8'h80, 32'h0000_5600, 4'h2);
		repeat (2) @(posedge clk_i);
		chk({fast_mode_o, dither_o}, 2'b11);
		chk(duty_o[11:0], 12'h158);
		wb(0, 8'h80, 0, 4'hF);
		chk(rd, 32'h0000_5600);
		wb(1, 8'h00, 32'h0000_0000, 4'h1);
		wb(1, 8'h84, 32'h0000_8158, 4'h3);
		wb(0, 8'h80, 0, 4'hF);
		chk(rd, 32'h0000_0158);
		chk({fast_mode_o, dither_o}, 2'b00);
		chk(duty_o[23:12], 12'h958);
		// Period of three ticks at every divider
		wb(1, 8'h08, 32'h0000_0003, 4'h3);
		wb(0, 8'h08, 0, 4'hF);
		chk(rd, 32'h0000_0003);
		chk(period_o, 32'h0000_0003);
		for (int c = 0; c < 4; c++) begin
			wb(1, 8'h00, 32'(c << 5), 4'h1);
			repeat (3) wait_ovf();
			chk(gap, 3 << c);
		end
		wb(1, 8'h00, 32'h0000_0000, 4'h1);
		wait_ovf();
		chk(gap, 24);
		wait_ovf();
		chk(gap, 3);
		// Flag, its write-one clear and the interrupt
		wb(1, 8'h04, 32'h0000_0001, 4'h1);
		wb(1, 8'h08, 32'h0000_0000, 4'h3);
		repeat (4) @(posedge clk_i);
		chk(irq_o, 1'b1);
		wb(1, 8'h00, 32'h0000_0000, 4'h1);
		wb(0, 8'h00, 0, 4'hF);
		chk(rd, 32'h0000_0001);
		wb(1, 8'h00, 32'h0000_0001, 4'h1);
		wb(0, 8'h00, 0, 4'hF);
		chk(rd, 32'h0000_0000);
		chk(irq_o, 1'b0);
		wb(1, 8'h04, 32'h0000_0000, 4'h1);
		wb(1, 8'h08, 32'h0000_0003, 4'h3);
		wait_ovf();
		repeat (3) @(posedge clk_i);
		wb(0, 8'h00, 0, 4'hF);
		chk(rd, 32'h0000_0001);
		chk(irq_o, 1'b0);
		// Dither hides period bit 0, so three acts as two
		wb(1, 8'h00, 32'h0000_0004, 4'h1);
		wb(0, 8'h08, 0, 4'hF);
		chk(rd, 32'h0000_0002);
		wait_ovf();
		wait_ovf();
		chk(gap, 2);
		// Wait mode with and without the halt select
		wb(1, 8'h00, 32'h0000_0010, 4'h1);
		wait_mode_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		t0 = tick_cnt;
		repeat (20) @(posedge clk_i);
		chk(pins_release_o, 1'b1);
		chk(tick_cnt - t0, 0);
		wb(1, 8'h00, 32'h0000_0000, 4'h1);
		repeat (2) @(posedge clk_i);
		chk(pins_release_o, 1'b0);
		wait_ovf();
		wait_ovf();
		chk(gap, 3);
		wait_mode_i <= 1'b0;
		results();
	end
endmodule
